// ===== asrl_pkg.sv
// constants and types for the eight-instance alarm setpoint relay block
//
// Behaviour
// - eight independent alarms, each fully configured
// - upper limit alone: trip at value >= limit
// - lower limit alone: trip at value <= limit
// - limits can be disabled; both reset disabled
// - upper above lower: trip outside the band
// - upper below lower: trip inside the band
// - upper alarm clears below limit minus deadband
// - lower alarm clears above limit plus deadband
// - one deadband per alarm, resets to 4.0
// - assert only after full continuous activation delay
// - condition dropout restarts the activation timer
// - activation delay per alarm, 0 to 6553.5 s
// - alarm held through release delay after clearing
// - condition return restarts the release timer
// - release delay per alarm, 0 to 6553.5 s
// - per-relay map bits drive relays, reset off
// - pi mode pins alarm 1,2 to relay 1,2
// - led flashes until acknowledged, then steady
package asrl_pkg;
    localparam int NUM_ALARMS = 8;
    localparam int NUM_RELAYS = 8;
    localparam int VALUE_W = 16;
    localparam int ADDR_W = 12;

    // per-alarm register window: base = index * stride
    localparam logic [ADDR_W-1:0] ALARM_STRIDE = 12'h020;
    localparam logic [2:0] FIELD_UPPER = 3'h0;
    localparam logic [2:0] FIELD_LOWER = 3'h1;
    localparam logic [2:0] FIELD_DEADBAND = 3'h2;
    localparam logic [2:0] FIELD_ACT_DLY = 3'h3;
    localparam logic [2:0] FIELD_REL_DLY = 3'h4;
    localparam logic [2:0] FIELD_MAP = 3'h5;
    localparam logic [2:0] FIELD_STATE = 3'h6;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h100;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h104;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h108;

    // limit register layout
    localparam int LIMIT_EN_BIT = 16;
    // state register layout
    localparam int ST_ALARM_BIT = 0;
    localparam int ST_COND_BIT = 1;
    localparam int ST_ACKED_BIT = 2;
    // control register layout
    localparam int CTRL_PI_BIT = 0;
    // irq status: asserted events low byte, released events high byte
    localparam int IRQ_REL_POS = 8;

    localparam logic [15:0] DEADBAND_RESET = 16'h0028;
    localparam logic [15:0] ACT_DLY_RESET = 16'h0000;
    localparam logic [15:0] REL_DLY_RESET = 16'h0000;
    localparam logic [7:0] MAP_RESET = 8'h00;

    localparam longint CLK_PERIOD_NS = 40;
    localparam longint TICK_PERIOD_NS = 100_000_000;
    localparam int TICK_CYCLES_DEFAULT = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);
    localparam int FLASH_TICKS = 5;

    typedef enum logic [1:0] {ASRL_IDLE, ASRL_ARMING, ASRL_ACTIVE, ASRL_RELEASING} asrl_state_t;
endpackage

// ===== asrl_alarm_relay.sv
// eight alarm evaluators with delays, relay mapping, annunciators and apb registers
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module asrl_alarm_relay #(
    parameter int TICK_CYCLES = asrl_pkg::TICK_CYCLES_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [asrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [asrl_pkg::NUM_ALARMS-1:0][asrl_pkg::VALUE_W-1:0] meas_value,
    input wire logic ack_button,
    input wire logic ack_remote,
    output logic [asrl_pkg::NUM_RELAYS-1:0] relay_out,
    output logic [asrl_pkg::NUM_ALARMS-1:0] led_out,
    output logic [asrl_pkg::NUM_ALARMS-1:0] trigger_instance,
    output logic irq
);
    import asrl_pkg::*;

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    localparam int NA = NUM_ALARMS;
    localparam int NR = NUM_RELAYS;
    localparam int TCW = $clog2(TICK_CYCLES);

    // ========================================================
    // condition evaluation with deadband
    // ========================================================
    function automatic logic eval_cond(input logic held, input logic [15:0] v,
                                       input logic [16:0] hi, input logic [16:0] lo,
                                       input logic [15:0] hyst);
        logic signed [17:0] sv;
        logic signed [17:0] shi;
        logic signed [17:0] slo;
        logic signed [17:0] shy;
        logic up;
        logic dn;
        sv = 18'($signed(v));
        shi = 18'($signed(hi[15:0]));
        slo = 18'($signed(lo[15:0]));
        shy = $signed({2'b00, hyst});
        if (held) begin
            up = sv >= (shi - shy);
            dn = sv <= (slo + shy);
        end else begin
            up = sv >= shi;
            dn = sv <= slo;
        end
        if (hi[LIMIT_EN_BIT] && lo[LIMIT_EN_BIT] && (shi < slo)) begin
            eval_cond = up && dn;
        end else begin
            eval_cond = (hi[LIMIT_EN_BIT] && up) || (lo[LIMIT_EN_BIT] && dn);
        end
    endfunction

    // ========================================================
    // configuration registers
    // ========================================================
    logic [16:0] upper_limit [NA];
    logic [16:0] falling_limit [NA];
    logic [15:0] deadband_width [NA];
    logic [15:0] activate_delay [NA];
    logic [15:0] release_delay [NA];
    logic [NR-1:0] output_map [NA];
    logic pi_mode;
    logic [15:0] irq_mask;
    logic [16:0] next_upper_limit [NA];
    logic [16:0] next_falling_limit [NA];
    logic [15:0] next_deadband_width [NA];
    logic [15:0] next_activate_delay [NA];
    logic [15:0] next_release_delay [NA];
    logic [NR-1:0] next_output_map [NA];
    logic next_pi_mode;
    logic [15:0] next_irq_mask;

    logic acc_done;
    logic wr_en;
    logic rd_en;
    logic in_alarm_win;
    logic [2:0] sel_alarm;
    logic [2:0] sel_field;
    logic addr_ok;

    assign in_alarm_win = paddr < ADDR_W'(NA * int'(ALARM_STRIDE));
    assign sel_alarm = paddr[7:5];
    assign sel_field = paddr[4:2];
    always_comb begin
        addr_ok = 1'b0;
        if (paddr[1:0] == 2'b00) begin
            if (in_alarm_win) begin
                addr_ok = sel_field <= FIELD_STATE;
            end else begin
                addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_IRQ_STATUS)
                          || (paddr == OFS_IRQ_MASK);
            end
        end
    end

    always_comb begin
        next_pi_mode = pi_mode;
        next_irq_mask = irq_mask;
        for (int i = 0; i < NA; i++) begin
            next_upper_limit[i] = upper_limit[i];
            next_falling_limit[i] = falling_limit[i];
            next_deadband_width[i] = deadband_width[i];
            next_activate_delay[i] = activate_delay[i];
            next_release_delay[i] = release_delay[i];
            next_output_map[i] = output_map[i];
        end
        if (wr_en && addr_ok) begin
            if (in_alarm_win) begin
                case (sel_field)
                    FIELD_UPPER: next_upper_limit[sel_alarm] = pwdata[16:0];
                    FIELD_LOWER: next_falling_limit[sel_alarm] = pwdata[16:0];
                    FIELD_DEADBAND: next_deadband_width[sel_alarm] = pwdata[15:0];
                    FIELD_ACT_DLY: next_activate_delay[sel_alarm] = pwdata[15:0];
                    FIELD_REL_DLY: next_release_delay[sel_alarm] = pwdata[15:0];
                    FIELD_MAP: next_output_map[sel_alarm] = pwdata[NR-1:0];
                    default: ;
                endcase
            end else if (paddr == OFS_CTRL) begin
                next_pi_mode = pwdata[CTRL_PI_BIT];
            end else if (paddr == OFS_IRQ_MASK) begin
                next_irq_mask = pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pi_mode <= 1'b0;
            irq_mask <= 16'h0000;
            for (int i = 0; i < NA; i++) begin
                upper_limit[i] <= 17'h0_0000;
                falling_limit[i] <= 17'h0_0000;
                deadband_width[i] <= DEADBAND_RESET;
                activate_delay[i] <= ACT_DLY_RESET;
                release_delay[i] <= REL_DLY_RESET;
                output_map[i] <= MAP_RESET;
            end
        end else if (ce) begin
            pi_mode <= next_pi_mode;
            irq_mask <= next_irq_mask;
            for (int i = 0; i < NA; i++) begin
                upper_limit[i] <= next_upper_limit[i];
                falling_limit[i] <= next_falling_limit[i];
                deadband_width[i] <= next_deadband_width[i];
                activate_delay[i] <= next_activate_delay[i];
                release_delay[i] <= next_release_delay[i];
                output_map[i] <= next_output_map[i];
            end
        end
    end

    // ========================================================
    // 10 Hz tick and flash phase
    // ========================================================
    logic [TCW-1:0] tick_cnt;
    logic [2:0] flash_cnt;
    logic flash_on;
    logic tick;
    logic [TCW-1:0] next_tick_cnt;
    logic [2:0] next_flash_cnt;
    logic next_flash_on;

    assign tick = tick_cnt == TCW'(TICK_CYCLES - 1);
    always_comb begin
        next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
        next_flash_cnt = flash_cnt;
        next_flash_on = flash_on;
        if (tick) begin
            if (flash_cnt == 3'(FLASH_TICKS - 1)) begin
                next_flash_cnt = 3'h0;
                next_flash_on = !flash_on;
            end else begin
                next_flash_cnt = flash_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= '0;
            flash_cnt <= 3'h0;
            flash_on <= 1'b0;
        end else if (ce) begin
            tick_cnt <= next_tick_cnt;
            flash_cnt <= next_flash_cnt;
            flash_on <= next_flash_on;
        end
    end

    // ========================================================
    // alarm engines
    // ========================================================
    asrl_state_t st [NA];
    logic [15:0] tcnt [NA];
    logic [NA-1:0] cond_q;
    logic [NA-1:0] acked;
    logic [NR-1:0] relay_q;
    asrl_state_t next_st [NA];
    logic [15:0] next_tcnt [NA];
    logic [NA-1:0] cond_now;
    logic [NA-1:0] next_acked;
    logic [NR-1:0] next_relay;
    logic [NA-1:0] next_alarm;
    logic ack_any;

    assign ack_any = ack_button || ack_remote;

    always_comb begin
        for (int i = 0; i < NA; i++) begin
            // deadband applies only once the alarm has activated
            cond_now[i] = eval_cond(cond_q[i] && trigger_instance[i], meas_value[i],
                                    upper_limit[i], falling_limit[i], deadband_width[i]);
            next_st[i] = st[i];
            next_tcnt[i] = tcnt[i];
            case (st[i])
                ASRL_IDLE: begin
                    next_tcnt[i] = 16'h0000;
                    if (cond_now[i]) begin
                        next_st[i] = (activate_delay[i] == 16'h0000) ? ASRL_ACTIVE : ASRL_ARMING;
                    end
                end
                ASRL_ARMING: begin
                    if (!cond_now[i]) begin
                        next_st[i] = ASRL_IDLE;
                        next_tcnt[i] = 16'h0000;
                    end else if (tick) begin
                        next_tcnt[i] = tcnt[i] + 16'h0001;
                        if ({1'b0, tcnt[i]} + 17'h0_0001 >= {1'b0, activate_delay[i]}) begin
                            next_st[i] = ASRL_ACTIVE;
                        end
                    end
                end
                ASRL_ACTIVE: begin
                    next_tcnt[i] = 16'h0000;
                    if (!cond_now[i]) begin
                        next_st[i] = (release_delay[i] == 16'h0000) ? ASRL_IDLE : ASRL_RELEASING;
                    end
                end
                ASRL_RELEASING: begin
                    if (cond_now[i]) begin
                        next_st[i] = ASRL_ACTIVE;
                    end else if (tick) begin
                        next_tcnt[i] = tcnt[i] + 16'h0001;
                        if ({1'b0, tcnt[i]} + 17'h0_0001 >= {1'b0, release_delay[i]}) begin
                            next_st[i] = ASRL_IDLE;
                        end
                    end
                end
                default: next_st[i] = ASRL_IDLE;
            endcase
            next_alarm[i] = (next_st[i] == ASRL_ACTIVE) || (next_st[i] == ASRL_RELEASING);
            next_acked[i] = next_alarm[i] && (acked[i] || (trigger_instance[i] && ack_any));
        end
        for (int r = 0; r < NR; r++) begin
            next_relay[r] = 1'b0;
            for (int i = 0; i < NA; i++) begin
                if (!(pi_mode && i < 2) && output_map[i][r]) begin
                    next_relay[r] = next_relay[r] || next_alarm[i];
                end
            end
        end
        if (pi_mode) begin
            next_relay[0] = next_alarm[0];
            next_relay[1] = next_alarm[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_q <= '0;
            acked <= '0;
            relay_q <= '0;
            for (int i = 0; i < NA; i++) begin
                st[i] <= ASRL_IDLE;
                tcnt[i] <= 16'h0000;
            end
        end else if (ce) begin
            cond_q <= cond_now;
            acked <= next_acked;
            relay_q <= next_relay;
            for (int i = 0; i < NA; i++) begin
                st[i] <= next_st[i];
                tcnt[i] <= next_tcnt[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NA; i++) begin
            trigger_instance[i] = (st[i] == ASRL_ACTIVE) || (st[i] == ASRL_RELEASING);
            led_out[i] = trigger_instance[i] && (acked[i] || flash_on);
        end
    end
    assign relay_out = relay_q;

    // ========================================================
    // interrupts and apb slave
    // ========================================================
    logic [15:0] irq_status;
    logic [NA-1:0] alarm_q;
    logic setup_seen;
    logic [31:0] rdata_q;
    logic err_q;
    logic [15:0] next_irq_status;
    logic next_setup_seen;
    logic [31:0] next_rdata;
    logic next_err;

    assign acc_done = psel && penable && ce && setup_seen;
    assign wr_en = acc_done && pwrite;
    assign rd_en = acc_done && !pwrite;
    assign pready = psel && penable && setup_seen && ce;
    assign prdata = rdata_q;
    assign pslverr = pready && err_q;
    assign irq = |(irq_status & irq_mask);

    always_comb begin
        next_setup_seen = psel && !penable;
        next_rdata = rdata_q;
        next_err = err_q;
        if (psel && !penable) begin
            next_err = !addr_ok;
            next_rdata = 32'h0000_0000;
            if (addr_ok && !pwrite) begin
                if (in_alarm_win) begin
                    case (sel_field)
                        FIELD_UPPER: next_rdata = {15'h0000, upper_limit[sel_alarm]};
                        FIELD_LOWER: next_rdata = {15'h0000, falling_limit[sel_alarm]};
                        FIELD_DEADBAND: next_rdata = {16'h0000, deadband_width[sel_alarm]};
                        FIELD_ACT_DLY: next_rdata = {16'h0000, activate_delay[sel_alarm]};
                        FIELD_REL_DLY: next_rdata = {16'h0000, release_delay[sel_alarm]};
                        FIELD_MAP: next_rdata = {24'h00_0000, output_map[sel_alarm]};
                        FIELD_STATE: begin
                            next_rdata[ST_ALARM_BIT] = trigger_instance[sel_alarm];
                            next_rdata[ST_COND_BIT] = cond_q[sel_alarm];
                            next_rdata[ST_ACKED_BIT] = acked[sel_alarm];
                        end
                        default: next_rdata = 32'h0000_0000;
                    endcase
                end else if (paddr == OFS_CTRL) begin
                    next_rdata[CTRL_PI_BIT] = pi_mode;
                end else if (paddr == OFS_IRQ_STATUS) begin
                    next_rdata = {16'h0000, irq_status};
                end else begin
                    next_rdata = {16'h0000, irq_mask};
                end
            end
        end
        next_irq_status = irq_status;
        if (rd_en && addr_ok && paddr == OFS_IRQ_STATUS) begin
            next_irq_status = irq_status & ~rdata_q[15:0];
        end
        // new events win over the read clear
        next_irq_status[NA-1:0] = next_irq_status[NA-1:0] | (trigger_instance & ~alarm_q);
        next_irq_status[IRQ_REL_POS +: NA] = next_irq_status[IRQ_REL_POS +: NA]
                                             | (~trigger_instance & alarm_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 16'h0000;
            alarm_q <= '0;
            setup_seen <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (ce) begin
            irq_status <= next_irq_status;
            alarm_q <= trigger_instance;
            setup_seen <= next_setup_seen;
            rdata_q <= next_rdata;
            err_q <= next_err;
        end
    end

    // ========================================================
    // assertions
    // ========================================================
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    for (genvar g = 0; g < NA; g++) begin : g_chk
        AST_DISABLED_QUIET: assert property (
            !upper_limit[g][LIMIT_EN_BIT] && !falling_limit[g][LIMIT_EN_BIT] |-> !cond_now[g])
            else $error("disabled limits produced a condition");
        AST_NO_DELAY_TRIP: assert property (
            ce && st[g] == ASRL_IDLE && cond_now[g] && activate_delay[g] == 16'h0000
            |=> trigger_instance[g])
            else $error("zero delay alarm did not assert");
        AST_ARM_RESTART: assert property (
            ce && st[g] == ASRL_ARMING && !cond_now[g] |=> st[g] == ASRL_IDLE && tcnt[g] == 16'h0000 ##1 !trigger_instance[g])
            else $error("activation timer not restarted");
        AST_ARM_HOLDS_OFF: assert property (
            st[g] == ASRL_ARMING && {1'b0, tcnt[g]} + 17'h0_0001 < {1'b0, activate_delay[g]}
            |=> !trigger_instance[g])
            else $error("alarm asserted before delay ran out");
        AST_REL_RESTART: assert property (
            ce && st[g] == ASRL_RELEASING && cond_now[g] |=> st[g] == ASRL_ACTIVE)
            else $error("release timer not restarted");
        AST_UPPER_DEADBAND: assert property (
            cond_q[g] && trigger_instance[g] && upper_limit[g][LIMIT_EN_BIT]
            && !falling_limit[g][LIMIT_EN_BIT]
            && $signed({{2{meas_value[g][15]}}, meas_value[g]})
            >= $signed({{2{upper_limit[g][15]}}, upper_limit[g][15:0]})
            - $signed({2'b00, deadband_width[g]}) |-> cond_now[g])
            else $error("upper alarm cleared inside deadband");
        AST_LED_STEADY: assert property (
            ce && acked[g] && next_alarm[g] |=> acked[g] && led_out[g])
            else $error("acknowledged alarm led not steady");
        AST_RELAY_FOLLOWS: assert property (
            ce && !pi_mode && g >= 2 && output_map[g][0] && next_alarm[g] |=> relay_out[0])
            else $error("mapped relay not driven");
    end
    AST_PI_RELAY: assert property (
        ce && pi_mode |=> relay_out[1:0] == trigger_instance[1:0])
        else $error("pi mode relay not tied to alarm");
endmodule
`default_nettype wire

// ===== asrl_scanner_model.sv
// measurement scanner model: holds the latest value of each alarm channel
`timescale 1ns/100ps
`default_nettype none
module asrl_scanner_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [2:0] sel,
    input wire logic [15:0] val,
    output logic [7:0][15:0] meas_value
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_value <= '0;
        end else if (load) begin
            meas_value[sel] <= val;
        end
    end
endmodule
`default_nettype wire

// ===== asrl_alarm_relay_test.sv
// self-checking bench for the alarm setpoint relay block
`timescale 1ns/100ps
`default_nettype none
module asrl_alarm_relay_test;
    import asrl_pkg::*;
    logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, irq;
    logic ack_button = 0, load = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [2:0] sel = 0;
    logic [15:0] val = 0;
    logic [7:0][15:0] meas;
    logic [7:0] relay_out, led_out, trig;
    int n_mismatch = 0, comparisons = 0;
    asrl_alarm_relay #(.TICK_CYCLES(10)) asrl_alarm_relay_inst (.pclk(pclk), .presetn(presetn),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas_value(meas), .ack_button(ack_button), .ack_remote(1'b0), .relay_out(relay_out),
        .led_out(led_out), .trigger_instance(trig), .irq(irq));
    asrl_scanner_model asrl_scanner_model_inst (.pclk(pclk), .presetn(presetn), .load(load),
        .sel(sel), .val(val), .meas_value(meas));
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    // =====
    // shared tasks
    task end_of_test();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task apb(input logic w, input int a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 12'(a);
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            end_of_test();
        end
        @(posedge pclk);
    endtask
    task wr(input int i, input int f, input logic [31:0] d);
        apb(1'b1, i * 32 + f * 4, d);
    endtask
    task rc(input int i, input int f, input logic [31:0] e);
        apb(1'b0, i * 32 + f * 4, 0);
        chk(rd, e);
    endtask
    task ms(input int i, input logic [15:0] v);
        sel <= 3'(i);
        val <= v;
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        @(posedge pclk);
    endtask
    task hold(input int i, input logic v, input int n);
        repeat (n) begin
            @(posedge pclk);
            chk(32'(trig[i]), 32'(v));
        end
    endtask
    task wt(input int i, input logic v, input int n);
        int k;
        k = 0;
        while (trig[i] !== v && k < n) begin
            @(posedge pclk);
            k++;
        end
        chk(32'(trig[i]), 32'(v));
        if (trig[i] !== v) end_of_test();
    endtask
    task led_count(output int c);
        c = 0;
        repeat (110) begin
            @(posedge pclk);
            if (led_out[0] === 1'b1) c++;
        end
    endtask
    // =====
    // scenarios
    task t_reset();
        chk(32'(relay_out), 0);
        for (int i = 0; i < 8; i++) begin
            rc(i, FIELD_DEADBAND, {16'h0000, DEADBAND_RESET});
            rc(i, FIELD_UPPER, 0);
            rc(i, FIELD_LOWER, 0);
        end
        rc(7, FIELD_ACT_DLY, 0);
        rc(7, FIELD_REL_DLY, 0);
        rc(7, FIELD_MAP, 0);
    endtask
    task t_limits();
        wr(0, FIELD_MAP, 32'h0000_0004);
        wr(0, FIELD_UPPER, 32'h0001_0064);
        ms(0, 16'h0063);
        hold(0, 1'b0, 3);
        ms(0, 16'h0064);
        wt(0, 1'b1, 5);
        chk(32'(relay_out), 32'h0000_0004);
        ms(0, 16'h003C);
        hold(0, 1'b1, 3);
        ms(0, 16'h003B);
        wt(0, 1'b0, 5);
        ms(1, 16'h000B);
        wr(1, FIELD_LOWER, 32'h0001_000A);
        hold(1, 1'b0, 3);
        ms(1, 16'h000A);
        wt(1, 1'b1, 5);
        ms(1, 16'h0032);
        hold(1, 1'b1, 3);
        ms(1, 16'h0033);
        wt(1, 1'b0, 5);
        ms(2, 16'h000F);
        wr(2, FIELD_UPPER, 32'h0001_0014);
        wr(2, FIELD_LOWER, 32'h0001_000A);
        hold(2, 1'b0, 3);
        ms(2, 16'h0005);
        wt(2, 1'b1, 5);
        ms(3, 16'h0032);
        wr(3, FIELD_LOWER, 32'h0001_0014);
        wr(3, FIELD_UPPER, 32'h0001_000A);
        hold(3, 1'b0, 3);
        ms(3, 16'h000F);
        wt(3, 1'b1, 5);
    endtask
    task t_delay();
        ms(4, 16'hFFF6);
        wr(4, FIELD_ACT_DLY, 3);
        wr(4, FIELD_REL_DLY, 4);
        wr(4, FIELD_MAP, 32'h0000_0001);
        wr(4, FIELD_UPPER, 32'h0001_0000);
        ms(4, 16'h0005);
        hold(4, 1'b0, 15);
        ms(4, 16'hFFC0);
        ms(4, 16'h0005);
        hold(4, 1'b0, 15);
        wt(4, 1'b1, 20);
        chk(32'(relay_out), 32'h0000_0001);
        ms(4, 16'hFFC0);
        hold(4, 1'b1, 25);
        chk(32'(relay_out), 32'h0000_0001);
        ms(4, 16'h0005);
        ms(4, 16'hFFC0);
        hold(4, 1'b1, 27);
        wt(4, 1'b0, 20);
        chk(32'(relay_out), 0);
    endtask
    task t_misc();
        int c;
        apb(1'b1, OFS_CTRL, 1);
        ms(0, 16'h0064);
        wt(0, 1'b1, 5);
        chk(32'(relay_out), 32'h0000_0001);
        led_count(c);
        chk(32'(c > 0 && c < 110), 1);
        ack_button <= 1'b1;
        @(posedge pclk);
        ack_button <= 1'b0;
        led_count(c);
        chk(c, 110);
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_00FF);
        chk(32'(irq), 1);
        apb(1'b0, OFS_IRQ_STATUS, 0);
        apb(1'b0, OFS_IRQ_STATUS, 0);
        chk(rd, 0);
        chk(32'(irq), 0);
        ms(0, 16'h003B);
        wt(0, 1'b0, 5);
        @(posedge pclk);
        chk(32'(irq), 0);
        apb(1'b0, OFS_IRQ_STATUS, 0);
        chk(rd, 32'h0000_0100);
        apb(1'b0, 32'h0000_0FFC, 0);
        chk(32'(er), 1);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_limits();
        t_delay();
        t_misc();
        end_of_test();
    end
endmodule
`default_nettype wire
